/* rtl/sfs_addr_gen.sv */
`timescale 1ns/100ps
// effective data-memory address for a byte-oriented file operand
module sfs_addr_gen (
  input  wire logic [7:0]  file_addr,
  input  wire logic        acc_sel,
  input  wire logic        xinst_en,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic [11:0] index_base,
  output logic      [11:0] eff_addr,
  output logic             indexed
);
  always_comb begin
    indexed = xinst_en && !acc_sel && (file_addr <= sfs_pkg::INDEXED_LIMIT); // RULE6
    if (indexed) begin
      eff_addr = index_base + {4'h0, file_addr}; // RULE6
    end else if (acc_sel) begin
      eff_addr = {bank_select_reg, file_addr}; // RULE5
    end else if (file_addr < sfs_pkg::ACCESS_SPLIT) begin
      eff_addr = {sfs_pkg::GPR_BANK0, file_addr}; // RULE5
    end else begin
      eff_addr = {sfs_pkg::SFR_BANK, file_addr}; // RULE5
    end
  end
endmodule // sfs_addr_gen

/* rtl/sfs_core.sv */
`timescale 1ns/100ps
// Function
// RULE1 - the set-all-ones opcode takes an 8-bit file address and access bit and writes ff to that register.
// RULE2 - sleep clears the watchdog count and postscaler, sets the timeout flag and clears the powerdown flag.
// RULE3 - once sleep completes the core sits in the sleep state with its oscillator stopped.
// RULE4 - a watchdog wake-up from sleep clears the timeout flag.
// RULE5 - access bit 0 selects the access bank ignoring the bank select, access bit 1 uses the bank select.
// RULE6 - with extended instructions on and access bit 0, addresses up to 5f are indexed literal offsets.
// RULE7 - each opcode is decoded from its fixed word and runs in one cycle of decode, read/nop, process, write/sleep.
module sfs_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // instruction issue, same clock domain
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  // wake events, from the watchdog timer or elsewhere, on the same clock
  input  wire logic        wdt_wake,
  input  wire logic        other_wake,
  // data memory write port
  output logic             mem_we,
  output logic      [11:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  // watchdog and power
  output logic      [7:0]  watchdog_timer,
  output logic             wdt_post_clr,
  output logic             osc_run,
  output logic             timeout_flag,
  output logic             powerdown_flag,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  sfs_pkg::sfs_phase_e phase_q, phase_d;
  logic [15:0] ir_q, ir_d;
  logic        busy_q, busy_d;
  logic        sleep_q, sleep_d;
  logic        to_q, to_d;
  logic        pd_q, pd_d;
  logic        wwake_q, wwake_d;
  logic [7:0]  wdt_q, wdt_d;
  logic        post_q, post_d;
  logic        we_q, we_d;
  logic [11:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        xinst_q, xinst_d;
  logic [3:0]  bank_sel_q, bank_sel_d;
  logic [11:0] fsr2_q, fsr2_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [11:0] eff_addr;
  logic        indexed;
  logic        is_set;
  logic        is_sleep;
  logic        apb_wr;
  logic        apb_rd;

  // opcode pattern match on the held instruction
  function automatic logic match_set(input logic [15:0] w);
    return (w & sfs_pkg::SET_OP_MASK) == sfs_pkg::SET_OP_VALUE; // RULE7
  endfunction

  assign is_set   = match_set(ir_q); // RULE1
  assign is_sleep = (ir_q == sfs_pkg::SLEEP_OPCODE); // RULE7

  sfs_addr_gen u_addr (
    .file_addr       (ir_q[7:0]),
    .acc_sel         (ir_q[sfs_pkg::ACC_BIT]),
    .xinst_en        (xinst_q),
    .bank_select_reg (bank_sel_q),
    .index_base      (fsr2_q),
    .eff_addr        (eff_addr),
    .indexed         (indexed)
  );

  // accept a new word only at q1 while awake
  assign instr_ready = !sleep_q && !busy_q && (phase_q == sfs_pkg::SFS_Q1);
  assign apb_wr      = psel && penable && pwrite;
  assign apb_rd      = psel && !penable && !pwrite;

  // phase sequencer and execution
  always_comb begin
    phase_d = phase_q;
    ir_d    = ir_q;
    busy_d  = busy_q;
    sleep_d = sleep_q;
    to_d    = to_q;
    pd_d    = pd_q;
    wwake_d = wwake_q;
    wdt_d   = wdt_q;
    post_d  = 1'b0;
    we_d    = 1'b0;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    if (sleep_q) begin
      // oscillator halted: phases frozen until a wake event
      if (wdt_wake) begin
        to_d    = 1'b0; // RULE4
        wwake_d = 1'b1; // RULE4
        sleep_d = 1'b0;
      end else if (other_wake) begin
        sleep_d = 1'b0;
      end
    end else begin
      case (phase_q)
        sfs_pkg::SFS_Q1: begin
          if (instr_valid) begin
            ir_d    = instr_word; // RULE7
            busy_d  = 1'b1;
            wwake_d = 1'b0;
          end
          if (instr_valid || busy_q) begin
            phase_d = sfs_pkg::SFS_Q2;
          end
        end
        sfs_pkg::SFS_Q2: begin
          phase_d = sfs_pkg::SFS_Q3; // read register or no operation
        end
        sfs_pkg::SFS_Q3: begin
          if (is_set) begin
            addr_d  = eff_addr; // RULE5
            wdata_d = sfs_pkg::ALL_ONES; // RULE1
          end
          phase_d = sfs_pkg::SFS_Q4;
        end
        sfs_pkg::SFS_Q4: begin
          wdt_d = wdt_q + 8'h01; // watchdog tick, one per instruction cycle
          if (is_set) begin
            we_d = 1'b1; // RULE1
          end else if (is_sleep) begin
            wdt_d   = sfs_pkg::WDT_CLEAR; // RULE2
            post_d  = 1'b1; // RULE2
            to_d    = 1'b1; // RULE2
            pd_d    = 1'b0; // RULE2
            sleep_d = 1'b1; // RULE3
          end
          busy_d  = 1'b0;
          phase_d = sfs_pkg::SFS_Q1; // RULE7
        end
        default: begin
          phase_d = sfs_pkg::SFS_Q1;
        end
      endcase
    end
    // software may restore both status flags; hardware events win
    if (apb_wr && (paddr == sfs_pkg::ADDR_CTRL) && pwdata[sfs_pkg::CTRL_SETFLAGS]) begin
      if (!(phase_q == sfs_pkg::SFS_Q4 && is_sleep && !sleep_q)) begin
        pd_d = 1'b1;
        if (!(sleep_q && wdt_wake)) begin
          to_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= sfs_pkg::SFS_Q1;
      ir_q    <= 16'h0000;
      busy_q  <= 1'b0;
      sleep_q <= 1'b0;
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
      wwake_q <= 1'b0;
      wdt_q   <= 8'h00;
      post_q  <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 12'h000;
      wdata_q <= 8'h00;
    end else if (clk_en) begin
      phase_q <= phase_d;
      ir_q    <= ir_d;
      busy_q  <= busy_d;
      sleep_q <= sleep_d;
      to_q    <= to_d;
      pd_q    <= pd_d;
      wwake_q <= wwake_d;
      wdt_q   <= wdt_d;
      post_q  <= post_d;
      we_q    <= we_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // apb register file
  always_comb begin
    xinst_d = xinst_q;
    bank_sel_d = bank_sel_q;
    fsr2_d  = fsr2_q;
    rdata_d = rdata_q;
    err_d   = 1'b0;
    if (apb_wr) begin
      if (paddr == sfs_pkg::ADDR_CTRL) begin
        xinst_d = pwdata[sfs_pkg::CTRL_XINST];
      end else if (paddr == sfs_pkg::ADDR_BANK_SEL) begin
        bank_sel_d = pwdata[3:0];
      end else if (paddr == sfs_pkg::ADDR_FSR2) begin
        fsr2_d = pwdata[11:0];
      end else if (paddr != sfs_pkg::ADDR_STATUS && paddr != sfs_pkg::ADDR_LASTWR) begin
        err_d = 1'b1;
      end
    end else if (apb_rd) begin
      if (paddr == sfs_pkg::ADDR_CTRL) begin
        rdata_d = {31'h00000000, xinst_q};
      end else if (paddr == sfs_pkg::ADDR_STATUS) begin
        rdata_d = {28'h0000000, wwake_q, sleep_q, pd_q, to_q};
      end else if (paddr == sfs_pkg::ADDR_BANK_SEL) begin
        rdata_d = {28'h0000000, bank_sel_q};
      end else if (paddr == sfs_pkg::ADDR_FSR2) begin
        rdata_d = {20'h00000, fsr2_q};
      end else if (paddr == sfs_pkg::ADDR_LASTWR) begin
        rdata_d = {11'h000, indexed, wdt_q, addr_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    if (psel && !penable && !pwrite) begin
      err_d = !(paddr == sfs_pkg::ADDR_CTRL || paddr == sfs_pkg::ADDR_STATUS || paddr == sfs_pkg::ADDR_BANK_SEL
                || paddr == sfs_pkg::ADDR_FSR2 || paddr == sfs_pkg::ADDR_LASTWR);
    end else if (psel && penable && !pwrite) begin
      err_d = err_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xinst_q <= 1'b0;
      bank_sel_q <= 4'h0;
      fsr2_q  <= 12'h000;
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else if (clk_en) begin
      xinst_q <= xinst_d;
      bank_sel_q <= bank_sel_d;
      fsr2_q  <= fsr2_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // outputs straight from flops, except pready (tied high), pslverr (combinational) and instr_ready (decoded from phase, busy and sleep)
  assign mem_we         = we_q;
  assign mem_addr       = addr_q;
  assign mem_wdata      = wdata_q;
  assign watchdog_timer = wdt_q;
  assign wdt_post_clr   = post_q;
  assign osc_run        = !sleep_q; // RULE3
  assign timeout_flag   = to_q;
  assign powerdown_flag = pd_q;
  assign prdata         = rdata_q;
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && (pwrite ? err_d : err_q);
endmodule // sfs_core

/* rtl/sfs_pkg.sv */
package sfs_pkg;
  // opcode patterns, single 16-bit word
  localparam logic [15:0] SET_OP_MASK   = 16'hfe00;
  localparam logic [15:0] SET_OP_VALUE  = 16'h6800;
  localparam logic [15:0] SLEEP_OPCODE  = 16'h0003;
  localparam int          ACC_BIT       = 8;
  // data values
  localparam logic [7:0]  ALL_ONES      = 8'hff;
  localparam logic [7:0]  WDT_CLEAR     = 8'h00;
  localparam logic [7:0]  INDEXED_LIMIT = 8'h5f;
  // access bank split: below 60 is gpr bank 0, 60 and up is sfr bank
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  SFR_BANK      = 4'hf;
  localparam logic [3:0]  GPR_BANK0     = 4'h0;
  // apb map
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_BANK_SEL = 12'h008;
  localparam logic [11:0] ADDR_FSR2     = 12'h00c;
  localparam logic [11:0] ADDR_LASTWR   = 12'h010;
  localparam int          CTRL_XINST    = 0;
  localparam int          CTRL_SETFLAGS = 1;
  localparam int          ST_TIMEOUT    = 0;
  localparam int          ST_POWERDOWN  = 1;
  localparam int          ST_SLEEPING   = 2;
  localparam int          ST_WDT_WAKE   = 3;
  // quarter-cycle phases
  typedef enum logic [3:0] {
    SFS_Q1 = 4'b0001,
    SFS_Q2 = 4'b0010,
    SFS_Q3 = 4'b0100,
    SFS_Q4 = 4'b1000
  } sfs_phase_e;
endpackage

/* verification/sfs_core_assertions.sv */
`timescale 1ns/100ps
// port-level checks for the core
module sfs_core_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic [15:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic        wdt_wake,
  input wire logic        other_wake,
  input wire logic        mem_we,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  watchdog_timer,
  input wire logic        wdt_post_clr,
  input wire logic        osc_run,
  input wire logic        timeout_flag,
  input wire logic        powerdown_flag
);
  logic set_take;
  logic slp_take;
  // opcodes accepted at the issue handshake
  assign set_take = instr_valid && instr_ready && clk_en
                    && ((instr_word & sfs_pkg::SET_OP_MASK) == sfs_pkg::SET_OP_VALUE);
  assign slp_take = instr_valid && instr_ready && clk_en && (instr_word == sfs_pkg::SLEEP_OPCODE);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SET_WRITE: assert property (set_take |-> ##4 mem_we && mem_wdata == sfs_pkg::ALL_ONES)
    else $error("set op gave no ff write four cycles on");
  AST_WE_CAUSE: assert property (mem_we |-> $past(set_take, 4))
    else $error("write strobe without a set op four cycles before");
  AST_BANK_ACCESS: assert property (set_take && !instr_word[8] && instr_word[7:0] >= sfs_pkg::ACCESS_SPLIT
    |-> ##4 mem_addr == {sfs_pkg::SFR_BANK, $past(instr_word[7:0], 4)})
    else $error("access bank upper half misaddressed");
  AST_SLEEP_ENTRY: assert property (slp_take |-> ##4 timeout_flag && !powerdown_flag && !osc_run
    && wdt_post_clr && watchdog_timer == sfs_pkg::WDT_CLEAR) else $error("sleep entry state wrong");
  AST_WAKE_WDT: assert property (clk_en && !osc_run && wdt_wake |=> osc_run && !timeout_flag)
    else $error("watchdog wake left timeout flag set");
  AST_WAKE_OTHER: assert property (clk_en && !osc_run && other_wake && !wdt_wake |=> osc_run && timeout_flag)
    else $error("other wake disturbed timeout flag");
  AST_READY_GAP: assert property (instr_valid && instr_ready && clk_en |=> !instr_ready [*3])
    else $error("issue accepted inside a running cycle");
  AST_ASLEEP_REFUSE: assert property (!osc_run |-> !instr_ready)
    else $error("issue accepted while asleep");
  AST_SLEEP_HOLD: assert property (!osc_run && !wdt_wake && !other_wake |=> !osc_run)
    else $error("oscillator restarted without a wake");
  // main scenarios reached
  cover property (set_take);
  cover property (slp_take);
  cover property (!osc_run && wdt_wake);
endmodule // sfs_core_assertions

/* verification/sfs_core_test.sv */
`timescale 1ns/100ps
// bench: drives the core and compares against a small address model
module sfs_core_test;
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, instr_valid = 1'b0, wdt_wake = 1'b0, other_wake = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, a, err;
  logic [15:0] instr_word = 16'h0000, rnd = 16'h5e23;
  logic [11:0] paddr = 12'h000, mem_addr, ea;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  mem_wdata, watchdog_timer, f;
  logic [11:0] exp_q[$];
  logic        instr_ready, mem_we, wdt_post_clr, osc_run, timeout_flag, powerdown_flag, pready, pslverr;
  int          miscompares = 0, samples_checked = 0, n;

  sfs_core u_sfs_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .wdt_wake(wdt_wake), .other_wake(other_wake),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .watchdog_timer(watchdog_timer),
    .wdt_post_clr(wdt_post_clr), .osc_run(osc_run), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // clock
  always #5 pclk = ~pclk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // a wait that ran out ends the run
  task guard(input int lim);
    if (n >= lim) begin
      miscompares++;
      finish_test();
    end
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    guard(20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue one opcode, wait until the cycle completes
  task issue(input logic [15:0] w);
    @(posedge pclk);
    instr_word <= w;
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    guard(20);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (instr_ready !== 1'b1 && osc_run !== 1'b0 && n < 8);
    chk("phases", n, 3);
  endtask

  // one-cycle wake pulse from the watchdog or elsewhere
  task wake(input logic by_wdt);
    @(posedge pclk);
    wdt_wake <= by_wdt;
    other_wake <= !by_wdt;
    @(posedge pclk);
    wdt_wake <= 1'b0;
    other_wake <= 1'b0;
    #1;
    chk("wake_osc", osc_run, 1'b1);
    chk("wake_to", timeout_flag, !by_wdt);
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      f = (i % 4 == 0) ? 8'h5f : (i % 4 == 1) ? 8'h60 : rnd[7:0];
      a = (i % 4 < 2) ? 1'b0 : rnd[8];
      apb(1'b1, sfs_pkg::ADDR_CTRL, 32'(i >= 8));
      apb(1'b1, sfs_pkg::ADDR_BANK_SEL, {28'h0, rnd[15:12]});
      apb(1'b1, sfs_pkg::ADDR_FSR2, {20'h0, rnd[11:0]});
      if (a) ea = {rnd[15:12], f};
      else if (i >= 8 && f <= 8'h5f) ea = rnd[11:0] + {4'h0, f};
      else if (f < 8'h60) ea = {4'h0, f};
      else ea = {4'hf, f};
      exp_q.push_back(ea);
      issue({7'h34, a, f});
      chk("we", mem_we, 1'b1);
      chk("wdata", mem_wdata, 8'hff);
      chk("addr", mem_addr, exp_q.pop_front());
    end
    apb(1'b0, sfs_pkg::ADDR_BANK_SEL, 32'h0);
    chk("bank_rd", rd, {28'h0, rnd[15:12]});
    issue(16'h6a00);
    chk("no_we", mem_we, 1'b0);
    $display("test set_ops done");
    issue(sfs_pkg::SLEEP_OPCODE);
    chk("to", timeout_flag, 1'b1);
    chk("pd", powerdown_flag, 1'b0);
    chk("wdt", watchdog_timer, 8'h00);
    chk("post", wdt_post_clr, 1'b1);
    chk("osc", osc_run, 1'b0);
    apb(1'b0, sfs_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h5);
    chk("refuse", instr_ready, 1'b0);
    // clock enable low: a watchdog wake must not land
    @(posedge pclk);
    clk_en <= 1'b0;
    wdt_wake <= 1'b1;
    repeat (2) @(posedge pclk);
    clk_en <= 1'b1;
    wdt_wake <= 1'b0;
    @(posedge pclk);
    #1;
    chk("frozen_osc", osc_run, 1'b0);
    chk("frozen_to", timeout_flag, 1'b1);
    wake(1'b1);
    issue(sfs_pkg::SLEEP_OPCODE);
    chk("to_again", timeout_flag, 1'b1);
    wake(1'b0);
    apb(1'b1, sfs_pkg::ADDR_CTRL, 32'h3);
    #1;
    chk("set_pd", powerdown_flag, 1'b1);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", err, 1'b1);
    $display("test sleep_wake done");
    finish_test();
  end
endmodule // sfs_core_test

bind sfs_core sfs_core_assertions u_sfs_core_assertions (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready), .wdt_wake(wdt_wake),
  .other_wake(other_wake), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .watchdog_timer(watchdog_timer), .wdt_post_clr(wdt_post_clr), .osc_run(osc_run),
  .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
